// ===== include/wide_reg_if.sv
// Byte bus between the CPU side and the wide timer registers
`timescale 1ns/10ps
interface wide_reg_if;
  import wide_reg_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;

  modport device (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata
  );
endinterface

// ===== include/wide_reg_pkg.sv
// Constants and types for the timer wide-register byte access block
//
// Function
// - Wide registers reached only as two bytes
// - One 8-bit high staging byte per timer
// - Staging byte shared by all registers of its timer
// - Low-byte access performs the full transfer
// - Low write loads staged high plus low
// - Low read copies high byte to staging
// - Software writes high byte before low
// - Software reads low byte before high
// - Main code blocks interrupts around access
// - One staged high byte may serve several
// - Timer2 capture/compare, timer3 capture/compare a/b
// - Timer module controlled through CPU I/O space
package wide_reg_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int WIDE_W = 16;

  // Byte addresses in the local I/O window
  localparam logic [3:0] T2_CAPT_L = 4'h0;
  localparam logic [3:0] T2_CAPT_H = 4'h1;
  localparam logic [3:0] T2_COMP_L = 4'h2;
  localparam logic [3:0] T2_COMP_H = 4'h3;
  localparam logic [3:0] T3_CAPT_L = 4'h4;
  localparam logic [3:0] T3_CAPT_H = 4'h5;
  localparam logic [3:0] T3_CMPA_L = 4'h6;
  localparam logic [3:0] T3_CMPA_H = 4'h7;
  localparam logic [3:0] T3_CMPB_L = 4'h8;
  localparam logic [3:0] T3_CMPB_H = 4'h9;

  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam logic [15:0] WIDE_RESET = 16'h0000;

  typedef enum logic [1:0] {
    host_idle,
    host_first,
    host_second,
    host_last
  } host_state_e;

endpackage

// ===== src/wide_reg_bank.sv
// Device end: wide timer registers with shared high-byte staging
`timescale 1ns/10ps
module wide_reg_bank (
  input wire logic clk,
  input wire logic rst,
  wide_reg_if.device bus,
  input wire logic t2_capture_load,
  input wire logic [wide_reg_pkg::WIDE_W-1:0] t2_capture_in,
  input wire logic t3_capture_load,
  input wire logic [wide_reg_pkg::WIDE_W-1:0] t3_capture_in,
  output logic [wide_reg_pkg::WIDE_W-1:0] timer2_capture_value,
  output logic [wide_reg_pkg::WIDE_W-1:0] timer2_compare_value,
  output logic [wide_reg_pkg::WIDE_W-1:0] timer3_capture_value,
  output logic [wide_reg_pkg::WIDE_W-1:0] timer3_compare_a_value,
  output logic [wide_reg_pkg::WIDE_W-1:0] timer3_compare_b_value
);
  import wide_reg_pkg::*;

  // ==========================================================
  // Staging bytes and wide registers
  // ==========================================================
  logic [DATA_W-1:0] t2_stage;
  logic [DATA_W-1:0] t3_stage;
  logic [DATA_W-1:0] next_t2_stage;
  logic [DATA_W-1:0] next_t3_stage;
  logic [WIDE_W-1:0] next_t2_capt;
  logic [WIDE_W-1:0] next_t2_comp;
  logic [WIDE_W-1:0] next_t3_capt;
  logic [WIDE_W-1:0] next_t3_cmpa;
  logic [WIDE_W-1:0] next_t3_cmpb;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;

  assign bus.rdata = rdata;

  always_comb begin
    next_t2_stage = t2_stage;
    next_t3_stage = t3_stage;
    next_t2_capt = t2_capture_load ? t2_capture_in : timer2_capture_value;
    next_t2_comp = timer2_compare_value;
    next_t3_capt = t3_capture_load ? t3_capture_in : timer3_capture_value;
    next_t3_cmpa = timer3_compare_a_value;
    next_t3_cmpb = timer3_compare_b_value;
    next_rdata = rdata;
    if (bus.wr) begin
      case (bus.addr)
        T2_CAPT_H, T2_COMP_H: begin
          next_t2_stage = bus.wdata;
        end
        T3_CAPT_H, T3_CMPA_H, T3_CMPB_H: begin
          next_t3_stage = bus.wdata;
        end
        T2_CAPT_L: begin
          next_t2_capt = {t2_stage, bus.wdata};
        end
        T2_COMP_L: begin
          next_t2_comp = {t2_stage, bus.wdata};
        end
        T3_CAPT_L: begin
          next_t3_capt = {t3_stage, bus.wdata};
        end
        T3_CMPA_L: begin
          next_t3_cmpa = {t3_stage, bus.wdata};
        end
        T3_CMPB_L: begin
          next_t3_cmpb = {t3_stage, bus.wdata};
        end
        default: begin
        end
      endcase
    end else if (bus.rd) begin
      case (bus.addr)
        T2_CAPT_L: begin
          next_rdata = timer2_capture_value[7:0];
          next_t2_stage = timer2_capture_value[15:8];
        end
        T2_COMP_L: begin
          next_rdata = timer2_compare_value[7:0];
          next_t2_stage = timer2_compare_value[15:8];
        end
        T3_CAPT_L: begin
          next_rdata = timer3_capture_value[7:0];
          next_t3_stage = timer3_capture_value[15:8];
        end
        T3_CMPA_L: begin
          next_rdata = timer3_compare_a_value[7:0];
          next_t3_stage = timer3_compare_a_value[15:8];
        end
        T3_CMPB_L: begin
          next_rdata = timer3_compare_b_value[7:0];
          next_t3_stage = timer3_compare_b_value[15:8];
        end
        T2_CAPT_H, T2_COMP_H: begin
          next_rdata = t2_stage;
        end
        T3_CAPT_H, T3_CMPA_H, T3_CMPB_H: begin
          next_rdata = t3_stage;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t2_stage <= STAGE_RESET;
      t3_stage <= STAGE_RESET;
      timer2_capture_value <= WIDE_RESET;
      timer2_compare_value <= WIDE_RESET;
      timer3_capture_value <= WIDE_RESET;
      timer3_compare_a_value <= WIDE_RESET;
      timer3_compare_b_value <= WIDE_RESET;
      rdata <= STAGE_RESET;
    end else begin
      t2_stage <= next_t2_stage;
      t3_stage <= next_t3_stage;
      timer2_capture_value <= next_t2_capt;
      timer2_compare_value <= next_t2_comp;
      timer3_capture_value <= next_t3_capt;
      timer3_compare_a_value <= next_t3_cmpa;
      timer3_compare_b_value <= next_t3_cmpb;
      rdata <= next_rdata;
    end
  end
endmodule

// ===== src/wide_reg_host.sv
// CPU end: splits 16-bit requests into ordered, uninterrupted byte pairs
`timescale 1ns/10ps
module wide_reg_host (
  input wire logic clk,
  input wire logic rst,
  wide_reg_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic [wide_reg_pkg::ADDR_W-1:0] req_low_addr,
  input wire logic [wide_reg_pkg::WIDE_W-1:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [wide_reg_pkg::WIDE_W-1:0] rsp_rdata
);
  import wide_reg_pkg::*;

  // ==========================================================
  // Two-byte sequencer
  // ==========================================================
  host_state_e state;
  host_state_e next_state;
  logic wr_q;
  logic next_wr_q;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [DATA_W-1:0] wlow;
  logic [DATA_W-1:0] next_wlow;
  logic [DATA_W-1:0] low_byte;
  logic [DATA_W-1:0] next_low_byte;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] next_wdata;
  logic wr;
  logic next_wr;
  logic rd;
  logic next_rd;
  logic next_busy;
  logic next_done;
  logic [WIDE_W-1:0] next_rsp;

  assign bus.addr = addr;
  assign bus.wdata = wdata;
  assign bus.wr = wr;
  assign bus.rd = rd;

  // Read data lags its strobe by one cycle
  always_comb begin
    next_state = state;
    next_wr_q = wr_q;
    next_base = base;
    next_wlow = wlow;
    next_low_byte = low_byte;
    next_addr = addr;
    next_wdata = wdata;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_busy = busy;
    next_done = 1'b0;
    next_rsp = rsp_rdata;
    case (state)
      host_idle: begin
        if (req) begin
          next_wr_q = req_write;
          next_base = req_low_addr;
          next_wlow = req_wdata[7:0];
          next_busy = 1'b1;
          next_state = host_first;
          if (req_write) begin
            next_addr = {req_low_addr[ADDR_W-1:1], 1'b1};
            next_wdata = req_wdata[15:8];
            next_wr = 1'b1;
          end else begin
            next_addr = req_low_addr;
            next_rd = 1'b1;
          end
        end
      end
      host_first: begin
        next_state = host_second;
        if (wr_q) begin
          next_addr = base;
          next_wdata = wlow;
          next_wr = 1'b1;
        end else begin
          next_addr = {base[ADDR_W-1:1], 1'b1};
          next_rd = 1'b1;
        end
      end
      host_second: begin
        // Low byte of a read stands on rdata now
        next_state = host_last;
        next_low_byte = bus.rdata;
      end
      host_last: begin
        // Staged high byte stands on rdata now
        next_state = host_idle;
        next_busy = 1'b0;
        next_done = 1'b1;
        if (!wr_q) begin
          next_rsp = {bus.rdata, low_byte};
        end
      end
      default: begin
        next_state = host_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= host_idle;
      wr_q <= 1'b0;
      base <= 4'h0;
      wlow <= STAGE_RESET;
      low_byte <= STAGE_RESET;
      addr <= 4'h0;
      wdata <= STAGE_RESET;
      wr <= 1'b0;
      rd <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rsp_rdata <= WIDE_RESET;
    end else begin
      state <= next_state;
      wr_q <= next_wr_q;
      base <= next_base;
      wlow <= next_wlow;
      low_byte <= next_low_byte;
      addr <= next_addr;
      wdata <= next_wdata;
      wr <= next_wr;
      rd <= next_rd;
      busy <= next_busy;
      done <= next_done;
      rsp_rdata <= next_rsp;
    end
  end
endmodule

// ===== test/testbench.sv
// Testbench joining host and bank ends over the byte bus
`timescale 1ns/10ps
module testbench;
  import wide_reg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_low_addr = 4'h0;
  logic [WIDE_W-1:0] req_wdata = 16'h0000;
  logic busy;
  logic done;
  logic [WIDE_W-1:0] rsp_rdata;
  logic t2_load = 1'b0;
  logic t3_load = 1'b0;
  logic [WIDE_W-1:0] cap_in = 16'h0000;
  logic [WIDE_W-1:0] val [5];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  wide_reg_if bus_if ();
  wide_reg_host i_wide_reg_host (.clk(clk), .rst(rst), .bus(bus_if.host),
    .req(req), .req_write(req_write), .req_low_addr(req_low_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done),
    .rsp_rdata(rsp_rdata));
  wide_reg_bank i_wide_reg_bank (.clk(clk), .rst(rst), .bus(bus_if.device),
    .t2_capture_load(t2_load), .t2_capture_in(cap_in),
    .t3_capture_load(t3_load), .t3_capture_in(cap_in),
    .timer2_capture_value(val[0]), .timer2_compare_value(val[1]),
    .timer3_capture_value(val[2]), .timer3_compare_a_value(val[3]),
    .timer3_compare_b_value(val[4]));
  wide_reg_properties i_wide_reg_properties (.clk(clk), .rst(rst),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .rd(bus_if.rd), .rdata(bus_if.rdata));
  always #12.5 clk = ~clk;
  // ==========================================
  // Shared tasks
  task automatic complete_run();
    $display("Errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, input logic [3:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_low_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    check({15'h0000, busy}, 16'h0001);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8);
    check({15'h0000, done}, 16'h0001);
    check(16'(n), 16'h0003);
    check({15'h0000, busy}, 16'h0000);
    @(posedge clk);
    #1;
    check({15'h0000, done}, 16'h0000);
  endtask
  function automatic logic [15:0] pat(input int i);
    return 16'hA05C + 16'(i) * 16'h1111;
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_write_read();
    for (int i = 0; i < 5; i++) begin
      op(1'b1, 4'(2 * i), pat(i));
      check(val[i], pat(i));
    end
    for (int i = 4; i >= 0; i--) begin
      op(1'b0, 4'(2 * i), 16'h0000);
      check(rsp_rdata, pat(i));
    end
  endtask
  task automatic t_staged();
    @(posedge clk);
    req <= 1'b1;
    req_write <= 1'b1;
    req_low_addr <= T2_COMP_L;
    req_wdata <= 16'h3C96;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
    check(val[1], pat(1));
    @(posedge clk);
    #1;
    check(val[1], 16'h3C96);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, busy}, 16'h0000);
  endtask
  task automatic t_shared();
    op(1'b1, T3_CMPA_L, 16'h7711);
    op(1'b1, T3_CMPB_L, 16'h7722);
    check(val[3], 16'h7711);
    check(val[4], 16'h7722);
  endtask
  task automatic t_capture();
    @(posedge clk);
    t2_load <= 1'b1;
    cap_in <= 16'h5AA5;
    @(posedge clk);
    t2_load <= 1'b0;
    t3_load <= 1'b1;
    cap_in <= 16'hC33C;
    @(posedge clk);
    t3_load <= 1'b0;
    #1;
    check(val[0], 16'h5AA5);
    check(val[2], 16'hC33C);
    op(1'b0, T3_CAPT_L, 16'h0000);
    check(rsp_rdata, 16'hC33C);
  endtask
  task automatic t_refused();
    @(posedge clk);
    req <= 1'b1;
    req_write <= 1'b1;
    req_low_addr <= T3_CMPB_L;
    req_wdata <= 16'h0F0F;
    @(posedge clk);
    req_wdata <= 16'hF0F0;
    @(posedge clk);
    req <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check(val[4], 16'h0F0F);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    for (int i = 0; i < 5; i++) begin
      check(val[i], WIDE_RESET);
    end
    check({14'h0000, busy, done}, 16'h0000);
    check(rsp_rdata, WIDE_RESET);
    t_write_read();
    t_staged();
    t_shared();
    t_capture();
    t_refused();
    op(1'b0, 4'hA, 16'h0000);
    check(rsp_rdata, 16'h0000);
    complete_run();
  end
endmodule

// ===== test/wide_reg_properties.sv
// Protocol checks on the byte bus between host and bank
`timescale 1ns/10ps
module wide_reg_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [wide_reg_pkg::ADDR_W-1:0] addr,
  input wire logic [wide_reg_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [wide_reg_pkg::DATA_W-1:0] rdata
);
  import wide_reg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // Byte steps of a wide access
  sequence hi_wr;
    wr && addr[0];
  endsequence
  sequence lo_wr;
    wr && !addr[0];
  endsequence
  sequence hi_rd;
    rd && !wr && addr[0];
  endsequence
  sequence lo_rd;
    rd && !wr && !addr[0];
  endsequence
  sequence write_pair;
    hi_wr ##1 lo_wr;
  endsequence
  // ==========================================
  // Assertions
  AST_ONE_STROBE: assert property (!(wr && rd))
    else $error("read and write strobes together");
  AST_HIGH_THEN_LOW: assert property (
    hi_wr |=> lo_wr and (addr == $past(addr) - 4'h1))
    else $error("high byte write not followed by its low byte");
  AST_LOW_THEN_HIGH: assert property (
    lo_rd |=> hi_rd and (addr == $past(addr) + 4'h1))
    else $error("low byte read not followed by its high byte");
  AST_LOW_WR_STAGED: assert property (
    wr && !addr[0] |-> $past(wr) && $past(addr) == addr + 4'h1)
    else $error("low byte write without staged high byte");
  AST_HIGH_RD_AFTER_LOW: assert property (
    rd && addr[0] |-> $past(rd) && $past(addr) == addr - 4'h1)
    else $error("high byte read without prior low read");
  AST_WRITE_PAIR_ENDS: assert property (
    write_pair |=> !wr && !rd)
    else $error("extra byte access after a write pair");
  AST_RDATA_HOLDS: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  AST_UNMAPPED_ZERO: assert property (
    rd && addr > 4'h9 |=> rdata == 8'h00)
    else $error("unmapped read did not return zero");
endmodule
